/* File: core/tnr_node.sv */
// Overview of operation
// - rates 156.25 Kbps to 5 Mbps supported
// - prescale 8..128, timeouts scale 1..32
// - multiplier field: 00 20 MHz, 01 40 MHz
// - multiplier write halts core, PLL locks 8us
// - host waits 1 ms, then restart 18H
// - host changes multiplier at most once
// - host sets high-rate flag above 5 Mbps
// - reconfigure on start, soft reset, 420 ms
// - burst: eight marks one space, 765 times
// - idle 41us starts 73us*(255-id) timer
// - timer expiry sends invitation to next id
// - silent 37.4us: next id, else release
// - invitations sweep ids 1 to 255
// - keep next id of node taking control
// - id zero is broadcast, never a node
// - destination taken from page offset 01h
// - receive command msb 0 drops broadcasts
// - timeouts from cfg bits 3,4, setup1 bit 5
// - response timeout 37.4us
// - idle timeout 41us
// - extension bits lengthen all three timeouts
// - all nodes share timeout settings
// - invitation: alert, 04h, destination twice
`timescale 1ns/1ps
`include "tnr_defs.svh"
module tnr_node #(
  parameter int TMR_W     = 40,
  parameter int RECON_CYC = `TNR_RECON_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  tnr_if.node                    bus,
  input  wire logic              line_active,
  input  wire logic              itt_to_me,
  input  wire logic              rx_pkt_valid,
  input  wire tnr_pkg::tnr_byte_t rx_pkt_did,
  input  wire tnr_pkg::tnr_byte_t ram_rdata,
  output logic                   line_tx_mark,
  output logic [10:0]            ram_addr,
  output logic                   rx_accept
);
  import tnr_pkg::*;

  if (TMR_W < 36 || RECON_CYC < 1) begin : g_chk
    $error("tnr_node: timer too narrow or count zero");
  end

  // ==========================================
  // registers
  tnr_node_st_t st_q;
  tnr_node_st_t st_d;
  tnr_byte_t    cfg_q;
  tnr_byte_t    set1_q;
  tnr_byte_t    set2_q;
  tnr_byte_t    node_q;
  tnr_byte_t    nid_q;
  tnr_byte_t    tx_did_q;
  tnr_byte_t    rdata_q;
  logic         fetch_q;
  logic         rx_bcast_q;
  logic         rx_en_q;
  logic         locked_q;
  logic         mark_q;
  logic         accept_q;
  logic [10:0]  ram_addr_q;
  logic [5:0]   pos_q;
  logic [9:0]   rep_q;
  logic [11:0]  sub_q;

  // ==========================================
  // register port decode
  wire wr_cmd  = bus.reg_wr && bus.reg_addr == `TNR_A_CMD;
  wire wr_cfg  = bus.reg_wr && bus.reg_addr == `TNR_A_CFG;
  wire wr_set1 = bus.reg_wr && bus.reg_addr == `TNR_A_SET1;
  wire wr_set2 = bus.reg_wr && bus.reg_addr == `TNR_A_SET2;
  wire wr_node = bus.reg_wr && bus.reg_addr == `TNR_A_NODE;
  wire op_txen = wr_cmd && bus.reg_wdata[2:0] == `TNR_OP_TXEN;
  wire op_rxen = wr_cmd && bus.reg_wdata[2:0] == `TNR_OP_RXEN;
  // only a changed field wakes the PLL; rewriting the same code is harmless
  wire mult_wr = wr_set2 && bus.reg_wdata[1:0] != set2_q[1:0];
  wire restart = wr_cmd && bus.reg_wdata == `TNR_CMD_RESTART && st_q == TNR_HALT && locked_q;
  wire srst    = wr_cfg && bus.reg_wdata[`TNR_CFG_SRST];

  // ==========================================
  // rate and timeout scaling
  // reserved multiplier codes fall back to the bypass clock
  wire       mult_x2 = set2_q[1:0] == `TNR_MULT_X2;
  wire [2:0] pre     = (set1_q[2:0] > `TNR_PRE_MAX) ? `TNR_PRE_MAX : set1_q[2:0];
  wire [3:0] rate_sh = {1'b0, pre} + {3'h0, !mult_x2};
  wire [3:0] ext_sh  = {2'h0, cfg_q[`TNR_CFG_ET2], cfg_q[`TNR_CFG_ET1]};
  wire [3:0] to_sh   = rate_sh + ext_sh + {3'h0, set1_q[`TNR_SET1_XTO]};
  wire [11:0] unit_len = 12'(`TNR_UNIT_CYC) << rate_sh;
  wire [11:0] half_len = unit_len >> 1;

  // ==========================================
  // serializer
  wire tx_busy = st_q == TNR_BURST || st_q == TNR_SEND;
  wire tick    = tx_busy && sub_q == unit_len - 12'h1;
  wire [10:0] nid_fr = {nid_q, 3'b011};
  wire [`TNR_ITT_LEN-1:0] itt_vec = {nid_fr, nid_fr, `TNR_EOT, 3'b011, 6'h3f};
  wire burst_bit = pos_q < 6'(`TNR_BURST_MARKS);
  wire cur_bit   = (st_q == TNR_BURST) ? burst_bit : itt_vec[pos_q];
  wire burst_end = pos_q == 6'(`TNR_BURST_LEN - 1) && rep_q == 10'(`TNR_BURST_REPS - 1);
  wire itt_end   = pos_q == 6'(`TNR_ITT_LEN - 1);
  wire ser_last  = tick && ((st_q == TNR_BURST && burst_end) || (st_q == TNR_SEND && itt_end));

  // ==========================================
  // timers
  logic             idle_done;
  logic             wait_done;
  logic             recon_done;
  logic             wstart;
  logic [TMR_W-1:0] wbase;
  logic [3:0]       wsh;
  // held in reload through the burst, so the watchdog also runs after a reset start
  wire recon_start = itt_to_me || st_d == TNR_BURST;
  wire [TMR_W-1:0] slot_base = TMR_W'(TMR_W'(`TNR_SLOT_CYC) * TMR_W'(`TNR_NID_MAX - node_q));

  tnr_timer #(.W(TMR_W)) u_idle (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (line_active || tx_busy),
    .base    (TMR_W'(`TNR_IDLE_CYC)),
    .shift   (to_sh),
    .done    (idle_done)
  );
  tnr_timer #(.W(TMR_W)) u_wait (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (wstart),
    .base    (wbase),
    .shift   (wsh),
    .done    (wait_done)
  );
  tnr_timer #(.W(TMR_W)) u_recon (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (recon_start),
    .base    (TMR_W'(RECON_CYC)),
    .shift   (to_sh),
    .done    (recon_done)
  );

  // ==========================================
  // sequencer
  always_comb begin
    st_d  = st_q;
    wstart = 1'b0;
    wbase = TMR_W'(`TNR_RESP_CYC);
    wsh   = to_sh;
    if (mult_wr) begin
      st_d   = TNR_HALT;
      wstart = 1'b1;
      wbase  = TMR_W'(`TNR_LOCK_CYC);
      wsh    = 4'h0;
    end else if (st_q == TNR_HALT) begin
      if (restart) begin
        st_d = TNR_BURST;
      end
    end else if (srst || recon_done) begin
      st_d = TNR_BURST;
    end else begin
      unique case (st_q)
        TNR_BURST: begin
          if (ser_last) begin
            st_d = TNR_LISTEN;
          end
        end
        TNR_LISTEN: begin
          if (itt_to_me) begin
            st_d = TNR_SEND;
          end else if (idle_done) begin
            st_d   = TNR_SLOT;
            wstart = 1'b1;
            wbase  = slot_base;
          end
        end
        TNR_SLOT: begin
          if (line_active) begin
            st_d = TNR_LISTEN;
          end else if (wait_done) begin
            st_d = TNR_SEND;
          end
        end
        TNR_SEND: begin
          if (ser_last) begin
            st_d   = TNR_RESP;
            wstart = 1'b1;
          end
        end
        TNR_RESP: begin
          if (line_active) begin
            st_d = TNR_LISTEN;
          end else if (wait_done) begin
            st_d = TNR_SEND;
          end
        end
        default: st_d = TNR_BURST;
      endcase
    end
  end

  // wrap skips the broadcast id so the sweep covers 1..255 only
  wire [7:0] nid_next = (nid_q == `TNR_NID_MAX) ? `TNR_NID_MIN : nid_q + 8'h1;
  wire       nid_inc  = st_q == TNR_RESP && st_d == TNR_SEND;
  wire       nid_self = st_q == TNR_BURST && st_d == TNR_LISTEN;
  wire       seq_rst  = st_d != st_q || !tx_busy;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q  <= TNR_BURST;
      nid_q <= `TNR_NODE_RST;
      pos_q <= 6'h0;
      rep_q <= 10'h0;
      sub_q <= 12'h0;
      mark_q <= 1'b0;
    end else begin
      st_q <= st_d;
      // the node that answers keeps nid unchanged for direct passing
      if (nid_self) begin
        nid_q <= node_q;
      end else if (nid_inc) begin
        nid_q <= nid_next;
      end
      sub_q <= (seq_rst || tick) ? 12'h0 : sub_q + 12'h1;
      if (seq_rst) begin
        pos_q <= 6'h0;
        rep_q <= 10'h0;
      end else if (tick) begin
        pos_q <= (st_q == TNR_BURST && pos_q == 6'(`TNR_BURST_LEN - 1)) ? 6'h0 : pos_q + 6'h1;
        rep_q <= (st_q == TNR_BURST && pos_q == 6'(`TNR_BURST_LEN - 1)) ? rep_q + 10'h1 : rep_q;
      end
      // a mark is a pulse in the first half of its interval
      mark_q <= tx_busy && !seq_rst && cur_bit && sub_q < half_len;
    end
  end

  // ==========================================
  // register file
  wire acc_did = (rx_pkt_did == `TNR_BCAST_ID) ? rx_bcast_q : rx_pkt_did == node_q;
  tnr_byte_t rsel;
  always_comb begin
    unique case (bus.reg_addr)
      `TNR_A_CMD:   rsel = 8'h00;
      `TNR_A_CFG:   rsel = cfg_q;
      `TNR_A_SET1:  rsel = set1_q;
      `TNR_A_SET2:  rsel = set2_q;
      `TNR_A_NODE:  rsel = node_q;
      `TNR_A_STAT:  rsel = {3'h0, rx_en_q, locked_q, st_q};
      `TNR_A_NID:   rsel = nid_q;
      `TNR_A_TXDID: rsel = tx_did_q;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_q <= `TNR_CFG_RST;
      set1_q <= `TNR_SET1_RST;
      set2_q <= `TNR_SET2_RST;
      node_q <= `TNR_NODE_RST;
      locked_q <= 1'b1;
      fetch_q <= 1'b0;
      tx_did_q <= 8'h00;
      rx_en_q <= 1'b0;
      rx_bcast_q <= 1'b0;
      rdata_q <= 8'h00;
      accept_q <= 1'b0;
      ram_addr_q <= 11'h0;
    end else begin
      if (wr_cfg) begin
        cfg_q <= bus.reg_wdata & ~(8'h01 << `TNR_CFG_SRST);
      end
      if (wr_set1) begin
        set1_q <= bus.reg_wdata;
      end
      if (wr_set2) begin
        set2_q <= bus.reg_wdata;
      end
      // id zero stays reserved for broadcast, so such a write is dropped
      if (wr_node && bus.reg_wdata != `TNR_BCAST_ID) begin
        node_q <= bus.reg_wdata;
      end
      if (mult_wr) begin
        locked_q <= 1'b0;
      end else if (st_q == TNR_HALT && wait_done) begin
        locked_q <= 1'b1;
      end
      if (op_txen) begin
        ram_addr_q <= {bus.reg_wdata[5:3], `TNR_DID_OFS};
      end
      fetch_q <= op_txen;
      if (fetch_q) begin
        tx_did_q <= ram_rdata;
      end
      if (op_rxen) begin
        rx_en_q <= 1'b1;
        rx_bcast_q <= bus.reg_wdata[7];
      end
      accept_q <= rx_pkt_valid && rx_en_q && acc_did;
      if (bus.reg_rd) begin
        rdata_q <= rsel;
      end
    end
  end

  assign bus.reg_rdata = rdata_q;
  assign line_tx_mark  = mark_q;
  assign ram_addr      = ram_addr_q;
  assign rx_accept     = accept_q;
endmodule

/* File: core/tnr_defs.svh */
`ifndef TNR_DEFS_SVH
`define TNR_DEFS_SVH
// ==========================================
// register offsets on the node register port
`define TNR_A_CMD        3'h0
`define TNR_A_CFG        3'h1
`define TNR_A_SET1       3'h2
`define TNR_A_SET2       3'h3
`define TNR_A_NODE       3'h4
`define TNR_A_STAT       3'h5
`define TNR_A_NID        3'h6
`define TNR_A_TXDID      3'h7
// ==========================================
// host controller's own register offsets
`define TNR_H_MULT       3'h3
`define TNR_H_STAT       3'h5
`define TNR_H_NSTAT      3'h6
`define TNR_H_NNID       3'h7
// ==========================================
// field positions and codes
`define TNR_CFG_ET1      3
`define TNR_CFG_ET2      4
`define TNR_CFG_SRST     7
`define TNR_SET1_XTO     5
`define TNR_SET2_EF      2
`define TNR_CMD_RESTART  8'h18
`define TNR_OP_TXEN      3'h3
`define TNR_OP_RXEN      3'h4
`define TNR_EOT          8'h04
`define TNR_MULT_X2      2'h1
`define TNR_PRE_MAX      3'h4
`define TNR_DID_OFS      8'h01
`define TNR_NID_MIN      8'h01
`define TNR_NID_MAX      8'hff
`define TNR_BCAST_ID     8'h00
// ==========================================
// reset values
`define TNR_CFG_RST      8'h00
`define TNR_SET1_RST     8'h00
`define TNR_SET2_RST     8'h00
`define TNR_NODE_RST     8'h01
// ==========================================
// timing, figures at 5 Mbps
`define TNR_CLK_MHZ      100
`define TNR_T_UNIT_NS    200
`define TNR_T_RESP_NS    37400
`define TNR_T_IDLE_NS    41000
`define TNR_T_SLOT_NS    73000
`define TNR_T_LOCK_NS    8000
`define TNR_T_RECON_MS   420
`define TNR_T_HWAIT_MS   1
`define TNR_CYC_NS(t)    (((t) * `TNR_CLK_MHZ + 999) / 1000)
`define TNR_CYC_MS(t)    ((t) * `TNR_CLK_MHZ * 1000)
`define TNR_UNIT_CYC     `TNR_CYC_NS(`TNR_T_UNIT_NS)
`define TNR_RESP_CYC     `TNR_CYC_NS(`TNR_T_RESP_NS)
`define TNR_IDLE_CYC     `TNR_CYC_NS(`TNR_T_IDLE_NS)
`define TNR_SLOT_CYC     `TNR_CYC_NS(`TNR_T_SLOT_NS)
`define TNR_LOCK_CYC     `TNR_CYC_NS(`TNR_T_LOCK_NS)
`define TNR_RECON_CYC    `TNR_CYC_MS(`TNR_T_RECON_MS)
`define TNR_HWAIT_CYC    `TNR_CYC_MS(`TNR_T_HWAIT_MS)
`define TNR_BURST_MARKS  8
`define TNR_BURST_LEN    9
`define TNR_BURST_REPS   765
`define TNR_ITT_LEN      39
`endif

/* File: core/tnr_pkg.sv */
package tnr_pkg;
  typedef logic [7:0] tnr_byte_t;
  typedef logic [2:0] tnr_addr_t;
  typedef enum logic [2:0] {
    TNR_HALT  = 3'b000,
    TNR_BURST = 3'b001,
    TNR_LISTEN = 3'b010,
    TNR_SLOT  = 3'b011,
    TNR_SEND  = 3'b100,
    TNR_RESP  = 3'b101
  } tnr_node_st_t;
  typedef enum logic [1:0] {
    TNR_H_IDLE = 2'b00,
    TNR_H_SETW = 2'b01,
    TNR_H_WAIT = 2'b10,
    TNR_H_CMD  = 2'b11
  } tnr_host_st_t;
endpackage

/* File: core/tnr_if.sv */
`timescale 1ns/1ps
interface tnr_if;
  import tnr_pkg::*;
  logic      reg_wr;
  logic      reg_rd;
  tnr_addr_t reg_addr;
  tnr_byte_t reg_wdata;
  tnr_byte_t reg_rdata;
  modport node (
    input  reg_wr,
    input  reg_rd,
    input  reg_addr,
    input  reg_wdata,
    output reg_rdata
  );
  modport host (
    output reg_wr,
    output reg_rd,
    output reg_addr,
    output reg_wdata,
    input  reg_rdata
  );
endinterface

/* File: core/tnr_timer.sv */
`timescale 1ns/1ps
module tnr_timer #(
  parameter int W = 40
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         start,
  input  wire logic [W-1:0] base,
  input  wire logic [3:0]   shift,
  output logic              done
);
  logic [W-1:0] cnt_q;
  logic         done_q;
  wire  [W-1:0] load = base << shift;

  if (W < 8) begin : g_chk
    $error("tnr_timer: width too small");
  end

  assign done = done_q;

  // restart wins over expiry, so a busy line keeps it from firing
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else begin
      done_q <= !start && (cnt_q == W'(1));
      if (start) begin
        cnt_q <= load;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - W'(1);
      end
    end
  end
endmodule

/* File: core/tnr_host.sv */
`timescale 1ns/1ps
`include "tnr_defs.svh"
module tnr_host #(
  parameter int HWAIT_CYC = `TNR_HWAIT_CYC
) (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire tnr_pkg::tnr_addr_t sw_addr,
  input  wire tnr_pkg::tnr_byte_t sw_wdata,
  input  wire logic               sw_wr,
  input  wire logic               sw_rd,
  output tnr_pkg::tnr_byte_t      sw_rdata,
  tnr_if.host                     bus
);
  import tnr_pkg::*;

  if (HWAIT_CYC < 1 || HWAIT_CYC > 32'h7fffffff) begin : g_chk
    $error("tnr_host: wait count out of range");
  end

  // ==========================================
  // state
  tnr_host_st_t hs_q;
  tnr_byte_t    set2_q;
  tnr_byte_t    nstat_q;
  tnr_byte_t    nnid_q;
  tnr_byte_t    rdata_q;
  tnr_byte_t    wdata_q;
  tnr_addr_t    addr_q;
  tnr_addr_t    paddr_q;
  logic         wr_q;
  logic         rd_q;
  logic         pend_q;
  logic         poll_q;
  logic         changed_q;
  logic         refused_q;
  logic [31:0]  cnt_q;

  // ==========================================
  // decode
  wire mult_req = sw_wr && sw_addr == `TNR_H_MULT;
  wire fwd_wr   = sw_wr && !mult_req && sw_addr <= `TNR_A_NODE;
  // only one multiplier change per hardware reset
  wire mult_ok  = mult_req && !changed_q && hs_q == TNR_H_IDLE;
  wire seq_wr   = !fwd_wr && (hs_q == TNR_H_SETW || hs_q == TNR_H_CMD);
  wire wait_end = hs_q == TNR_H_WAIT && cnt_q == 32'h0;
  wire [7:0] seq_data = (hs_q == TNR_H_CMD) ? `TNR_CMD_RESTART : set2_q;
  wire [2:0] seq_addr = (hs_q == TNR_H_CMD) ? `TNR_A_CMD : `TNR_A_SET2;
  wire [2:0] poll_addr = poll_q ? `TNR_A_NID : `TNR_A_STAT;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hs_q <= TNR_H_IDLE;
      set2_q <= `TNR_SET2_RST;
      changed_q <= 1'b0;
      refused_q <= 1'b0;
      cnt_q <= 32'h0;
    end else begin
      if (mult_ok) begin
        // high-rate flag is carried from the request into second_config_register
        set2_q <= {5'h0, sw_wdata[`TNR_SET2_EF], sw_wdata[1:0]};
        changed_q <= 1'b1;
        hs_q <= TNR_H_SETW;
      end else if (mult_req) begin
        refused_q <= 1'b1;
      end
      if (hs_q == TNR_H_SETW && seq_wr) begin
        hs_q <= TNR_H_WAIT;
        cnt_q <= 32'(HWAIT_CYC - 1);
      end else if (hs_q == TNR_H_WAIT) begin
        cnt_q <= cnt_q - 32'h1;
        if (wait_end) begin
          hs_q <= TNR_H_CMD;
        end
      end else if (hs_q == TNR_H_CMD && seq_wr) begin
        hs_q <= TNR_H_IDLE;
      end
    end
  end

  // ==========================================
  // bus driver: software write, then sequence write, then status poll
  // timeout settings pass unchanged so every node can be given the same values
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 3'h0;
      wdata_q <= 8'h00;
      pend_q <= 1'b0;
      paddr_q <= 3'h0;
      poll_q <= 1'b0;
      nstat_q <= 8'h00;
      nnid_q <= 8'h00;
      rdata_q <= 8'h00;
    end else begin
      wr_q <= fwd_wr || seq_wr;
      rd_q <= !fwd_wr && !seq_wr;
      addr_q <= fwd_wr ? sw_addr : (seq_wr ? seq_addr : poll_addr);
      wdata_q <= fwd_wr ? sw_wdata : seq_data;
      if (!fwd_wr && !seq_wr) begin
        poll_q <= !poll_q;
      end
      pend_q <= rd_q;
      // the poll address moves on every cycle without a write, so match each answer to its own read
      paddr_q <= addr_q;
      if (pend_q && paddr_q == `TNR_A_STAT) begin
        nstat_q <= bus.reg_rdata;
      end
      if (pend_q && paddr_q == `TNR_A_NID) begin
        nnid_q <= bus.reg_rdata;
      end
      if (sw_rd) begin
        rdata_q <= (sw_addr == `TNR_H_STAT) ? {5'h0, refused_q, changed_q, hs_q != TNR_H_IDLE} :
                   (sw_addr == `TNR_H_NSTAT) ? nstat_q :
                   (sw_addr == `TNR_H_NNID) ? nnid_q : 8'h00;
      end
    end
  end

  assign bus.reg_wr    = wr_q;
  assign bus.reg_rd    = rd_q;
  assign bus.reg_addr  = addr_q;
  assign bus.reg_wdata = wdata_q;
  assign sw_rdata      = rdata_q;
endmodule

/* File: bench/tnr_bus_sva.sv */
`timescale 1ns/1ps
`include "tnr_defs.svh"
// ==========================================
// host-to-node register traffic checker
module tnr_bus_sva #(
  parameter int HWAIT_CYC = 900
) (
  input wire logic               sys_clk,
  input wire logic               rst,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire tnr_pkg::tnr_addr_t reg_addr,
  input wire tnr_pkg::tnr_byte_t reg_wdata,
  input wire tnr_pkg::tnr_byte_t reg_rdata
);
  import tnr_pkg::*;
  localparam int HW_HI = HWAIT_CYC + 16;
  logic [1:0]  mult_wr_q;
  logic [15:0] since_q;
  logic        armed_q;
  wire         mult_wr    = reg_wr && (reg_addr == `TNR_A_SET2);
  wire         restart_wr = reg_wr && (reg_addr == `TNR_A_CMD) && (reg_wdata == `TNR_CMD_RESTART);
  // ==========================================
  // wait bookkeeping, saturating so a long run cannot wrap into a false pass
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mult_wr_q <= 2'h0;
      since_q   <= 16'h0;
      armed_q   <= 1'b0;
    end else begin
      if (mult_wr && (mult_wr_q != 2'h3)) begin
        mult_wr_q <= mult_wr_q + 2'h1;
      end
      armed_q <= armed_q | mult_wr;
      since_q <= mult_wr ? 16'h0 : ((since_q == 16'hffff) ? since_q : since_q + 16'h1);
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_mult_wr;
    mult_wr;
  endsequence
  sequence s_restart;
    restart_wr;
  endsequence
  property p_excl;
    !(reg_wr && reg_rd);
  endproperty
  property p_poll;
    (!$past(rst) && !reg_wr) |-> reg_rd;
  endproperty
  property p_rdata_hold;
    (!$past(rst) && !$past(reg_rd)) |-> $stable(reg_rdata);
  endproperty
  property p_release;
    $past(rst) |-> (reg_rdata == 8'h00) ##1 reg_rd;
  endproperty
  property p_mult_once;
    mult_wr_q <= 2'h1;
  endproperty
  property p_restart_wait;
    s_restart |-> (armed_q && (since_q >= HWAIT_CYC - 1));
  endproperty
  property p_restart_follows;
    s_mult_wr |-> ##[1:HW_HI] s_restart;
  endproperty
  property p_set2_fields;
    s_mult_wr |-> (reg_wdata[7:3] == 5'h00);
  endproperty
  a_excl: assert property (p_excl) else $error("read and write strobes together");
  a_poll: assert property (p_poll) else $error("status polling stopped");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
  a_release: assert property (p_release) else $error("bad state after reset release");
  a_mult_once: assert property (p_mult_once) else $error("multiplier written twice");
  a_restart_wait: assert property (p_restart_wait) else $error("restart issued too early");
  a_restart_follows: assert property (p_restart_follows) else $error("restart missing");
  a_set2_fields: assert property (p_set2_fields) else $error("setup write has stray bits");
endmodule

/* File: bench/token_net_reconfig_timing_tb.sv */
`timescale 1ns/1ps
`include "tnr_defs.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; $display("[FAIL] %0t: got %h exp %h", $time, a, b); end end
module token_net_reconfig_timing_tb;
  import tnr_pkg::*;
  typedef struct packed {tnr_byte_t e; tnr_byte_t m;} tnr_note_t;
  localparam int HWAIT = 900;
  logic        sys_clk = 1'b0;
  logic        rst;
  tnr_addr_t   sw_addr;
  tnr_byte_t   sw_wdata;
  logic        sw_wr;
  logic        sw_rd;
  tnr_byte_t   sw_rdata;
  logic        line_active;
  logic        itt_to_me;
  logic        rx_pkt_valid;
  tnr_byte_t   rx_pkt_did;
  tnr_byte_t   ram_rdata;
  logic        line_tx_mark;
  logic [10:0] ram_addr;
  logic        rx_accept;
  tnr_note_t   notes[$];
  logic        acc_q[$];
  tnr_note_t   nt;
  logic        rd_d = 1'b0;
  logic        pv_d = 1'b0;
  tnr_byte_t   last_rd = 8'h00;
  tnr_byte_t   id;
  int          miscompares = 0;
  int          tests_run = 0;
  // ==========================================
  // both ends joined through the register carrier
  tnr_if bus_if ();
  tnr_host #(.HWAIT_CYC(HWAIT)) u_tnr_host (.sys_clk(sys_clk), .rst(rst), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .bus(bus_if));
  tnr_node #(.RECON_CYC(20000)) u_tnr_node (.sys_clk(sys_clk), .rst(rst), .bus(bus_if),
    .line_active(line_active), .itt_to_me(itt_to_me), .rx_pkt_valid(rx_pkt_valid),
    .rx_pkt_did(rx_pkt_did), .ram_rdata(ram_rdata), .line_tx_mark(line_tx_mark),
    .ram_addr(ram_addr), .rx_accept(rx_accept));
  tnr_bus_sva #(.HWAIT_CYC(HWAIT)) u_sva (.sys_clk(sys_clk), .rst(rst), .reg_wr(bus_if.reg_wr),
    .reg_rd(bus_if.reg_rd), .reg_addr(bus_if.reg_addr), .reg_wdata(bus_if.reg_wdata),
    .reg_rdata(bus_if.reg_rdata));
  always #5 sys_clk = ~sys_clk;
  // ==========================================
  // drivers
  task automatic sw_write(input tnr_addr_t a, input tnr_byte_t d);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge sys_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_read(input tnr_addr_t a, input tnr_byte_t e, input tnr_byte_t m);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    notes.push_back({e, m});
    @(posedge sys_clk);
    sw_rd <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic pkt(input tnr_byte_t destination_node_identifier, input logic exp);
    @(posedge sys_clk);
    rx_pkt_valid <= 1'b1;
    rx_pkt_did <= destination_node_identifier;
    acc_q.push_back(exp);
    @(posedge sys_clk);
    rx_pkt_valid <= 1'b0;
  endtask
  // whole pattern periods only, so the count does not depend on phase
  task automatic marks(input int n, input int exp);
    int   cnt;
    logic prev;
    cnt = 0;
    @(posedge sys_clk);
    prev = line_tx_mark;
    repeat (n) begin
      @(posedge sys_clk);
      if (line_tx_mark && !prev) cnt++;
      prev = line_tx_mark;
    end
    `CHK(cnt, exp)
  endtask
  task automatic conclude;
    $display("checks run %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========================================
  // result watcher
  always @(posedge sys_clk) begin
    rd_d <= sw_rd;
    pv_d <= rx_pkt_valid;
    if (rd_d && notes.size() > 0) begin
      nt = notes.pop_front();
      last_rd = sw_rdata;
      if (nt.m != 8'h00) `CHK(sw_rdata & nt.m, nt.e)
    end
    if (pv_d && acc_q.size() > 0) `CHK(rx_accept, acc_q.pop_front())
    else if (rx_accept === 1'b1) `CHK(rx_accept, 1'b0)
  end
  // token invitations reload the reconfigure watchdog (RECON_CYC 20000 here); the burst itself also holds it in reload
  initial begin
    wait (rst === 1'b0);
    forever begin
      repeat ($urandom_range(700, 300)) @(posedge sys_clk);
      itt_to_me <= 1'b1;
      ram_rdata <= 8'($urandom);
      @(posedge sys_clk);
      itt_to_me <= 1'b0;
    end
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    miscompares++;
    $display("[FAIL] %0t: watchdog expired", $time);
    conclude();
  end
  // ==========================================
  // main sequence
  initial begin
    void'($urandom(11890));
    rst = 1'b1;
    sw_addr = 3'h0;
    sw_wdata = 8'h00;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    line_active = 1'b0;
    itt_to_me = 1'b0;
    rx_pkt_valid = 1'b0;
    rx_pkt_did = 8'h00;
    ram_rdata = 8'h00;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (8) @(posedge sys_clk);
    sw_read(`TNR_H_STAT, 8'h00, 8'hff);
    sw_read(`TNR_H_NSTAT, 8'h09, 8'h1f);
    sw_read(`TNR_H_NNID, 8'h01, 8'hff);
    marks(3600, 80);
    sw_write(`TNR_A_NODE, 8'h00);
    sw_write(`TNR_A_CMD, 8'h04);
    repeat (4) @(posedge sys_clk);
    pkt(8'h01, 1'b1);
    pkt(8'h00, 1'b0);
    id = 8'($urandom_range(254, 2));
    sw_write(`TNR_A_CMD, 8'h84);
    sw_write(`TNR_A_NODE, id);
    repeat (4) @(posedge sys_clk);
    pkt(8'h00, 1'b1);
    pkt(id, 1'b1);
    pkt(id + 8'h01, 1'b0);
    pkt(8'h01, 1'b0);
    sw_read(`TNR_H_NSTAT, 8'h19, 8'h1f);
    sw_write(`TNR_A_CMD, 8'h2b);
    repeat (4) @(posedge sys_clk);
    `CHK(ram_addr, {3'h5, `TNR_DID_OFS})
    sw_write(`TNR_H_MULT, 8'h01);
    sw_write(`TNR_H_MULT, 8'h00);
    repeat (20) @(posedge sys_clk);
    sw_read(`TNR_H_NSTAT, 8'h00, 8'h0f);
    sw_read(`TNR_H_STAT, 8'h01, 8'h01);
    repeat (600) if (last_rd[0] === 1'b1) sw_read(`TNR_H_STAT, 8'h00, 8'h00);
    sw_read(`TNR_H_STAT, 8'h06, 8'hff);
    repeat (8) @(posedge sys_clk);
    sw_read(`TNR_H_NSTAT, 8'h09, 8'h0f);
    marks(1800, 80);
    sw_write(`TNR_A_SET1, 8'h04);
    repeat (3000) @(posedge sys_clk);
    marks(11520, 32);
    conclude();
  end
endmodule
